// File: logic/gjd_top.sv
// shared pin function, jack-detect debounce and output-enable masking
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - three-bit code picks shared pin function
// - pin is input after reset; mode-dependent use
// - three-wire mode forces pin to chip select
// - invert bit affects output only, not detection
// - pin control bit 6 enables pull-down
// - pin control bit 7 enables pull-up
// - pin control bit 8 selects open drain
// - bits 5:4 divide pll clock by 1-4
// - same field sets high-pass cutoff
// - detect switching from pins in two-wire mode
// - debounce on 2^21-cycle tick, gated by enable
// - no detect switching without slow tick enabled
// - low set when level 0, high when 1
// - effective enable is normal AND detect enable
// - detect disabled forces detect enables to ones
// - bits 5:4 choose detect source pin
// - line pins detect only; shared pin either
// - two 4-bit enable sets, bits 3:0, 7:4
module gjd_top
#(
    parameter int TICK_CYCLES = gjd_pkg::SLOW_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                         clock_in,
    input  wire logic                         rst_in,
    // register port
    input  wire logic                         reg_write_in,
    input  wire logic                         reg_read_in,
    input  wire logic [gjd_pkg::ADDR_W-1:0]   reg_addr_in,
    input  wire logic [gjd_pkg::DATA_W-1:0]   reg_wdata_in,
    output logic      [gjd_pkg::DATA_W-1:0]   reg_rdata_out,
    // pins
    input  wire logic                         mode_pin_in,
    input  wire logic                         shared_select_pin_in,
    output logic                              shared_select_pin_out,
    output logic                              shared_select_pin_oe_out,
    output logic                              pin_pull_up_en_out,
    output logic                              pin_pull_down_en_out,
    input  wire logic                         left_line_detect_pin_in,
    input  wire logic                         right_line_detect_pin_in,
    // internal flags and pll enable
    input  wire logic                         temp_ok_in,
    input  wire logic                         auto_mute_in,
    input  wire logic                         pll_lock_in,
    input  wire logic                         pll_tick_in,
    // output enables
    input  wire logic [gjd_pkg::NUM_OUTPUTS-1:0] normal_en_in,
    output logic      [gjd_pkg::NUM_OUTPUTS-1:0] out_en_out,
    // status toward the rest of the device
    output logic                              chip_select_in_out,
    output logic      [1:0]                   highpass_cutoff_select_out,
    output logic                              detect_level_out
);
    import gjd_pkg::*;

    logic [8:0] slow_r, slow_nxt;
    logic [8:0] pf_r, pf_nxt;
    logic [8:0] dp_r, dp_nxt;
    logic [8:0] do_r, do_nxt;
    logic [8:0] cm_r, cm_nxt;
    logic [8:0] rdata_r, rdata_nxt;

    logic [3:0] s1_r, s2_r, s3_r, clean_r, clean_nxt;

    logic       pin_r, pin_nxt;
    logic       oe_r, oe_nxt;
    logic       pu_r, pd_r;
    logic       cs_r, cs_nxt;
    logic [NUM_OUTPUTS-1:0] en_r, en_nxt;

    logic       three_wire;
    logic [2:0] fn_sel;
    logic [1:0] src_sel;
    logic [1:0] div_code;
    logic       det_en;
    logic       slow_en;
    logic       det_raw;
    logic       sample_en;
    logic       det_level;
    logic       div_clk;
    logic       gp_val;
    logic       out_val;
    logic       drive;
    logic [NUM_OUTPUTS-1:0] jd_mask;

    assign three_wire = clean_r[LN_MODE];
    assign fn_sel     = pf_r[PF_SEL_LSB +: 3];
    assign src_sel    = dp_r[DP_SEL_LSB +: 2];
    assign div_code   = cm_r[CM_DIV_LSB +: 2];
    assign det_en     = dp_r[DP_EN_BIT];
    assign slow_en    = slow_r[SC_EN_BIT];

    // registers; software reset write restores all defaults
    always_comb begin
        slow_nxt  = slow_r;
        pf_nxt    = pf_r;
        dp_nxt    = dp_r;
        do_nxt    = do_r;
        cm_nxt    = cm_r;
        rdata_nxt = rdata_r;
        if (reg_write_in) begin
            case (reg_addr_in)
                ADDR_SOFT_RESET: begin
                    slow_nxt = RST_SLOW_CLOCK;
                    pf_nxt   = RST_PIN_FUNC;
                    dp_nxt   = RST_DETECT_PIN;
                    do_nxt   = RST_DETECT_OUTS;
                    cm_nxt   = RST_CONV_MISC;
                end
                ADDR_SLOW_CLOCK:  slow_nxt = reg_wdata_in;
                ADDR_PIN_FUNC:    pf_nxt   = reg_wdata_in;
                ADDR_DETECT_PIN:  dp_nxt   = reg_wdata_in;
                ADDR_DETECT_OUTS: do_nxt   = reg_wdata_in;
                ADDR_CONV_MISC:   cm_nxt   = reg_wdata_in;
                default:          slow_nxt = slow_r;
            endcase
        end
        if (reg_read_in) begin
            case (reg_addr_in)
                ADDR_SLOW_CLOCK:  rdata_nxt = slow_r;
                ADDR_PIN_FUNC:    rdata_nxt = pf_r;
                ADDR_DETECT_PIN:  rdata_nxt = dp_r;
                ADDR_DETECT_OUTS: rdata_nxt = do_r;
                ADDR_CONV_MISC:   rdata_nxt = cm_r;
                ADDR_PIN_STATUS:  rdata_nxt = {5'h00, clean_r[LN_SHARED], three_wire,
                                               oe_r, det_level};
                default:          rdata_nxt = 9'h000;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            slow_r  <= RST_SLOW_CLOCK;
            pf_r    <= RST_PIN_FUNC;
            dp_r    <= RST_DETECT_PIN;
            do_r    <= RST_DETECT_OUTS;
            cm_r    <= RST_CONV_MISC;
            rdata_r <= 9'h000;
        end else begin
            slow_r  <= slow_nxt;
            pf_r    <= pf_nxt;
            dp_r    <= dp_nxt;
            do_r    <= do_nxt;
            cm_r    <= cm_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // pin synchronisers: a change counts once stages two and three agree
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            clean_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : clean_r[i];
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s1_r    <= 4'h0;
            s2_r    <= 4'h0;
            s3_r    <= 4'h0;
            clean_r <= 4'h0;
        end else begin
            s1_r    <= {mode_pin_in, right_line_detect_pin_in,
                        left_line_detect_pin_in, shared_select_pin_in};
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            clean_r <= clean_nxt;
        end
    end

    gjd_clk_div u_clk_div (
        .clock_in    (clock_in),
        .rst_in      (rst_in),
        .tick_in     (pll_tick_in),
        .div_code_in (div_code),
        .clk_out     (div_clk)
    );

    // detect source; raw pin level, never the inverted output value
    always_comb begin
        det_raw   = det_level;
        sample_en = 1'b0;
        case (src_sel)
            SRC_SHARED: begin
                det_raw   = clean_r[LN_SHARED];
                sample_en = (fn_sel == FN_INPUT) || (fn_sel == FN_RESERVED);
            end
            SRC_LEFT: begin
                det_raw   = clean_r[LN_LEFT];
                sample_en = 1'b1;
            end
            SRC_RIGHT: begin
                det_raw   = clean_r[LN_RIGHT];
                sample_en = 1'b1;
            end
            default: begin
                det_raw   = det_level;
                sample_en = 1'b0;
            end
        endcase
        sample_en = sample_en && det_en && !three_wire;
    end

    gjd_debounce #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_debounce (
        .clock_in     (clock_in),
        .rst_in       (rst_in),
        .slow_en_in   (slow_en),
        .sample_en_in (sample_en),
        .raw_in       (det_raw),
        .level_out    (det_level),
        .tick_out     ()
    );

    // pin drive, masking and chip select
    always_comb begin
        case (fn_sel)
            FN_TEMP_OK:    gp_val = temp_ok_in;
            FN_AUTO_MUTE:  gp_val = auto_mute_in;
            FN_PLL_CLOCK:  gp_val = div_clk;
            FN_PLL_LOCK:   gp_val = pll_lock_in;
            FN_DRIVE_HIGH: gp_val = 1'b1;
            default:       gp_val = 1'b0;
        endcase
        out_val = gp_val ^ pf_r[PF_INV_BIT];
        // input and reserved codes leave the pin undriven
        drive   = !three_wire && (fn_sel != FN_INPUT) && (fn_sel != FN_RESERVED);
        if (pf_r[PF_OD_BIT]) begin
            pin_nxt = 1'b0;
            oe_nxt  = drive && !out_val;
        end else begin
            pin_nxt = out_val;
            oe_nxt  = drive;
        end
        cs_nxt  = three_wire ? clean_r[LN_SHARED] : 1'b1;
        if (det_en) begin
            jd_mask = det_level ? do_r[DO_HIGH_LSB +: NUM_OUTPUTS]
                                : do_r[DO_LOW_LSB +: NUM_OUTPUTS];
        end else begin
            jd_mask = {NUM_OUTPUTS{1'b1}};
        end
        en_nxt = normal_en_in & jd_mask;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin_r <= 1'b0;
            oe_r  <= 1'b0;
            pu_r  <= 1'b0;
            pd_r  <= 1'b0;
            cs_r  <= 1'b1;
            en_r  <= {NUM_OUTPUTS{1'b0}};
        end else begin
            pin_r <= pin_nxt;
            oe_r  <= oe_nxt;
            pu_r  <= pf_r[PF_PU_BIT];
            pd_r  <= pf_r[PF_PD_BIT];
            cs_r  <= cs_nxt;
            en_r  <= en_nxt;
        end
    end

    assign reg_rdata_out              = rdata_r;
    assign shared_select_pin_out      = pin_r;
    assign shared_select_pin_oe_out   = oe_r;
    assign pin_pull_up_en_out         = pu_r;
    assign pin_pull_down_en_out       = pd_r;
    assign chip_select_in_out         = cs_r;
    assign out_en_out                 = en_r;
    assign highpass_cutoff_select_out = div_code;
    assign detect_level_out           = det_level;

    a_three_wire_cs: assert property (@(posedge clock_in) disable iff (rst_in)
        three_wire |=> (!shared_select_pin_oe_out && chip_select_in_out == $past(clean_r[0])))
        else $error("shared pin not a chip select in three-wire mode");
    a_input_undriven: assert property (@(posedge clock_in) disable iff (rst_in)
        (fn_sel == FN_INPUT) |=> !shared_select_pin_oe_out)
        else $error("shared pin driven while set as input");
    a_drive_high: assert property (@(posedge clock_in) disable iff (rst_in)
        (fn_sel == FN_DRIVE_HIGH && pf_r[8:3] == 6'h00 && !three_wire)
        |=> (shared_select_pin_oe_out && shared_select_pin_out))
        else $error("drive-one code did not drive the pin high");
    a_invert_output: assert property (@(posedge clock_in) disable iff (rst_in)
        (fn_sel == FN_DRIVE_LOW && pf_r[PF_INV_BIT] && !pf_r[PF_OD_BIT] && !three_wire)
        |=> (shared_select_pin_oe_out && shared_select_pin_out))
        else $error("inverted drive-zero did not read high");
    a_open_drain: assert property (@(posedge clock_in) disable iff (rst_in)
        pf_r[PF_OD_BIT] |=> !(shared_select_pin_oe_out && shared_select_pin_out))
        else $error("open drain pin drove high");
    a_pull_up_en: assert property (@(posedge clock_in) disable iff (rst_in)
        pf_r[PF_PU_BIT] |=> pin_pull_up_en_out)
        else $error("pull-up not enabled");
    a_pull_down_en: assert property (@(posedge clock_in) disable iff (rst_in)
        !pf_r[PF_PD_BIT] |=> !pin_pull_down_en_out)
        else $error("pull-down enabled while bit clear");
    a_detect_off_mask: assert property (@(posedge clock_in) disable iff (rst_in)
        !det_en |=> (out_en_out == $past(normal_en_in)))
        else $error("outputs masked while detection disabled");
    a_mask_and: assert property (@(posedge clock_in) disable iff (rst_in)
        1'b1 |=> ((out_en_out & ~$past(normal_en_in)) == 4'h0))
        else $error("output enabled without its normal enable");
    a_mask_select: assert property (@(posedge clock_in) disable iff (rst_in)
        (det_en && det_level) |=> (out_en_out == $past(normal_en_in & do_r[7:4])))
        else $error("high detect set not applied");
    a_three_wire_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        (three_wire ##1 three_wire) |=> $stable(det_level))
        else $error("detect level moved in three-wire mode");
endmodule
`default_nettype wire

// File: logic/gjd_pkg.sv
// constants for jack-detect and shared pin logic
package gjd_pkg;
    localparam int          ADDR_W           = 7;
    localparam int          DATA_W           = 9;
    localparam int          NUM_OUTPUTS      = 4;
    // register offsets
    localparam logic [6:0]  ADDR_SOFT_RESET  = 7'h00;
    localparam logic [6:0]  ADDR_SLOW_CLOCK  = 7'h07;
    localparam logic [6:0]  ADDR_PIN_FUNC    = 7'h08;
    localparam logic [6:0]  ADDR_DETECT_PIN  = 7'h09;
    localparam logic [6:0]  ADDR_DETECT_OUTS = 7'h0d;
    localparam logic [6:0]  ADDR_CONV_MISC   = 7'h0e;
    localparam logic [6:0]  ADDR_PIN_STATUS  = 7'h30;
    // reset values
    localparam logic [8:0]  RST_SLOW_CLOCK   = 9'h000;
    localparam logic [8:0]  RST_PIN_FUNC     = 9'h000;
    localparam logic [8:0]  RST_DETECT_PIN   = 9'h000;
    localparam logic [8:0]  RST_DETECT_OUTS  = 9'h000;
    localparam logic [8:0]  RST_CONV_MISC    = 9'h000;
    // field positions
    localparam int          SC_EN_BIT        = 0;
    localparam int          PF_SEL_LSB       = 0;
    localparam int          PF_INV_BIT       = 3;
    localparam int          PF_PD_BIT        = 6;
    localparam int          PF_PU_BIT        = 7;
    localparam int          PF_OD_BIT        = 8;
    localparam int          DP_SEL_LSB       = 4;
    localparam int          DP_EN_BIT        = 6;
    localparam int          DO_LOW_LSB       = 0;
    localparam int          DO_HIGH_LSB      = 4;
    localparam int          CM_DIV_LSB       = 4;
    // pin function codes
    localparam logic [2:0]  FN_INPUT         = 3'h0;
    localparam logic [2:0]  FN_RESERVED      = 3'h1;
    localparam logic [2:0]  FN_TEMP_OK       = 3'h2;
    localparam logic [2:0]  FN_AUTO_MUTE     = 3'h3;
    localparam logic [2:0]  FN_PLL_CLOCK     = 3'h4;
    localparam logic [2:0]  FN_PLL_LOCK      = 3'h5;
    localparam logic [2:0]  FN_DRIVE_LOW     = 3'h6;
    localparam logic [2:0]  FN_DRIVE_HIGH    = 3'h7;
    // detect source codes
    localparam logic [1:0]  SRC_SHARED       = 2'h0;
    localparam logic [1:0]  SRC_LEFT         = 2'h1;
    localparam logic [1:0]  SRC_RIGHT        = 2'h2;
    // slow tick period in master-clock cycles
    localparam int          SLOW_TICK_CYCLES = 2097152;
    // synchroniser lane indices
    localparam int          LN_SHARED        = 0;
    localparam int          LN_LEFT          = 1;
    localparam int          LN_RIGHT         = 2;
    localparam int          LN_MODE          = 3;
endpackage

// File: logic/gjd_debounce.sv
// slow tick generator and detect-level debouncer
`timescale 1ns/1ns
`default_nettype none
module gjd_debounce #(
    parameter int TICK_CYCLES = 2097152
) (
    // clock and reset
    input  wire logic clock_in,
    input  wire logic rst_in,
    // control
    input  wire logic slow_en_in,
    input  wire logic sample_en_in,
    input  wire logic raw_in,
    // results
    output logic      level_out,
    output logic      tick_out
);
    localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [TW-1:0] LAST = TW'(TICK_CYCLES - 1);

    logic [TW-1:0] cnt_r;
    logic [TW-1:0] cnt_nxt;
    logic          tick_r;
    logic          tick_nxt;
    logic          last_r;
    logic          last_nxt;
    logic          level_r;
    logic          level_nxt;

    always_comb begin
        cnt_nxt   = cnt_r;
        tick_nxt  = 1'b0;
        last_nxt  = last_r;
        level_nxt = level_r;
        // counter parks while disabled, so the tick is gated
        if (slow_en_in) begin
            if (cnt_r == LAST) begin
                cnt_nxt  = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + TW'(1);
            end
        end
        // level moves only if the same value is seen on two ticks
        if (tick_r && sample_en_in) begin
            last_nxt = raw_in;
            if (raw_in == last_r) begin
                level_nxt = raw_in;
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r   <= '0;
            tick_r  <= 1'b0;
            last_r  <= 1'b0;
            level_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            tick_r  <= tick_nxt;
            last_r  <= last_nxt;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;
    assign tick_out  = tick_r;

    a_hold_when_off: assert property (@(posedge clock_in) disable iff (rst_in)
        (!slow_en_in ##1 !slow_en_in) |=> $stable(level_r))
        else $error("detect level moved with slow tick disabled");
    a_tick_spacing: assert property (@(posedge clock_in) disable iff (rst_in)
        (tick_r && TICK_CYCLES > 1) |=> !tick_r)
        else $error("slow tick fired on consecutive cycles");
endmodule
`default_nettype wire

// File: logic/gjd_clk_div.sv
// divider for the pll clock sent to the shared pin
`timescale 1ns/1ns
`default_nettype none
module gjd_clk_div (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // pll half-period enable and ratio code
    input  wire logic       tick_in,
    input  wire logic [1:0] div_code_in,
    // divided clock level
    output logic            clk_out
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       clk_r;
    logic       clk_nxt;

    // code n divides by n+1: toggle every n+1 half periods
    always_comb begin
        cnt_nxt = cnt_r;
        clk_nxt = clk_r;
        if (tick_in) begin
            if (cnt_r >= div_code_in) begin
                cnt_nxt = 2'h0;
                clk_nxt = ~clk_r;
            end else begin
                cnt_nxt = cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= 2'h0;
            clk_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign clk_out = clk_r;

    a_div_by_one: assert property (@(posedge clock_in) disable iff (rst_in)
        (tick_in && div_code_in == 2'h0) |=> (clk_r != $past(clk_r)))
        else $error("divide by one did not toggle on each tick");
    a_div_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        (tick_in && cnt_r < div_code_in) |=> $stable(clk_r))
        else $error("divided clock toggled early");
endmodule
`default_nettype wire

// File: dv/gjd_jack_model.sv
// jack switch and board wiring on the pin side of the block
`timescale 1ns/1ns
`default_nettype none
module gjd_jack_model (
    // board and jack controls
    input  wire logic three_wire_in,
    input  wire logic jack_in,
    input  wire logic left_in,
    input  wire logic right_in,
    // what the device does to the shared pin
    input  wire logic oe_in,
    input  wire logic out_in,
    input  wire logic pu_in,
    input  wire logic pd_in,
    // pin levels
    output logic      mode_pin_out,
    output logic      shared_pin_out,
    output logic      left_pin_out,
    output logic      right_pin_out
);
    assign mode_pin_out   = three_wire_in;
    // device drive wins; an enabled pull then overrides the jack contact level
    assign shared_pin_out = oe_in ? out_in : pu_in ? 1'b1 : pd_in ? 1'b0 : jack_in;
    assign left_pin_out   = left_in;
    assign right_pin_out  = right_in;
endmodule
`default_nettype wire

// File: dv/gpio_jack_detect_switch_bench.sv
// self-checking bench for the shared pin and jack-detect block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module gpio_jack_detect_switch_bench;
    import gjd_pkg::*;
    logic       clock_in = 0, rst_in = 1, reg_write_in = 0, reg_read_in = 0;
    logic [6:0] reg_addr_in = '0;
    logic [8:0] reg_wdata_in = '0, reg_rdata_out;
    logic       mode_pin_in, shared_select_pin_in, shared_select_pin_out;
    logic       shared_select_pin_oe_out, pin_pull_up_en_out, pin_pull_down_en_out;
    logic       left_line_detect_pin_in, right_line_detect_pin_in;
    logic       temp_ok_in = 0, auto_mute_in = 0, pll_lock_in = 0, pll_tick_in = 0;
    logic [3:0] normal_en_in = 4'hf, out_en_out;
    logic       chip_select_in_out, detect_level_out;
    logic [1:0] highpass_cutoff_select_out;
    logic       three_w = 0, jack = 0, left = 0, right = 0;
    int         n_mismatch = 0, tests_run = 0, cyc = 0;

    always #25 clock_in = ~clock_in;

    gjd_top #(.TICK_CYCLES(8)) i_dut (.clock_in, .rst_in, .reg_write_in, .reg_read_in,
        .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .mode_pin_in, .shared_select_pin_in,
        .shared_select_pin_out, .shared_select_pin_oe_out, .pin_pull_up_en_out,
        .pin_pull_down_en_out, .left_line_detect_pin_in, .right_line_detect_pin_in,
        .temp_ok_in, .auto_mute_in, .pll_lock_in, .pll_tick_in, .normal_en_in, .out_en_out,
        .chip_select_in_out, .highpass_cutoff_select_out, .detect_level_out);

    gjd_jack_model i_model (.three_wire_in(three_w), .jack_in(jack), .left_in(left),
        .right_in(right), .oe_in(shared_select_pin_oe_out), .out_in(shared_select_pin_out),
        .pu_in(pin_pull_up_en_out), .pd_in(pin_pull_down_en_out),
        .mode_pin_out(mode_pin_in), .shared_pin_out(shared_select_pin_in),
        .left_pin_out(left_line_detect_pin_in), .right_pin_out(right_line_detect_pin_in));

    task automatic summarize();
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge clock_in);
        reg_write_in = 1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clock_in);
        reg_write_in = 0;
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [8:0] exp);
        @(negedge clock_in);
        reg_read_in = 1;
        reg_addr_in = a;
        @(negedge clock_in);
        reg_read_in = 0;
        `CHK(reg_rdata_out, exp)
    endtask

    // settle past synchronisers and output registers
    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        @(negedge clock_in);
    endtask

    // count pin toggles over 12 cycles with a pll tick on every cycle
    task automatic pll_toggles(input int exp);
        int   n = 0;
        logic prev;
        pll_tick_in = 1;
        repeat (4) @(negedge clock_in);
        prev = shared_select_pin_out;
        repeat (12) begin
            @(negedge clock_in);
            if (shared_select_pin_out !== prev) n++;
            prev = shared_select_pin_out;
        end
        pll_tick_in = 0;
        `CHK(n, exp)
    endtask

    task automatic wait_level(input logic v);
        for (int i = 0; i < 80 && detect_level_out !== v; i++) settle(1);
    endtask

    task automatic t_defaults();
        rd_chk(ADDR_PIN_FUNC, RST_PIN_FUNC);
        rd_chk(ADDR_DETECT_PIN, RST_DETECT_PIN);
        rd_chk(ADDR_DETECT_OUTS, RST_DETECT_OUTS);
        rd_chk(ADDR_CONV_MISC, RST_CONV_MISC);
        rd_chk(7'h55, 9'h000);
        `CHK(shared_select_pin_oe_out, 1'b0)
        `CHK(out_en_out, 4'hf)
    endtask

    task automatic t_functions();
        logic [8:0] cfg [10] = '{9'h006, 9'h007, 9'h00f, 9'h002, 9'h00a,
                                 9'h005, 9'h107, 9'h106, 9'h003, 9'h001};
        logic [1:0] exp [10] = '{2'b10, 2'b11, 2'b10, 2'b11, 2'b10,
                                 2'b10, 2'b00, 2'b10, 2'b10, 2'b00};
        temp_ok_in = 1;
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_PIN_FUNC, cfg[i]);
            settle(2);
            `CHK({shared_select_pin_oe_out, shared_select_pin_out}, exp[i])
        end
        wr(ADDR_PIN_FUNC, 9'h0c1);
        settle(2);
        `CHK({pin_pull_up_en_out, pin_pull_down_en_out, shared_select_pin_oe_out}, 3'b110)
        wr(ADDR_PIN_FUNC, 9'h007);
    endtask

    task automatic t_three_wire();
        three_w = 1;
        // mode sync, drive release, then pin level sync again
        settle(12);
        `CHK({shared_select_pin_oe_out, chip_select_in_out}, 2'b00)
        jack = 1;
        settle(8);
        `CHK(chip_select_in_out, 1'b1)
        three_w = 0;
        jack = 0;
        wr(ADDR_PIN_FUNC, 9'h000);
        settle(8);
    endtask

    task automatic t_cutoff();
        wr(ADDR_CONV_MISC, 9'h020);
        `CHK(highpass_cutoff_select_out, 2'h2)
        rd_chk(ADDR_CONV_MISC, 9'h020);
        wr(ADDR_PIN_FUNC, 9'h004);
        pll_toggles(4);
        wr(ADDR_CONV_MISC, 9'h000);
        `CHK(highpass_cutoff_select_out, 2'h0)
        pll_toggles(12);
        wr(ADDR_PIN_FUNC, 9'h000);
    endtask

    task automatic t_detect();
        wr(ADDR_DETECT_OUTS, 9'h05a);
        wr(ADDR_SLOW_CLOCK, 9'h001);
        wr(ADDR_DETECT_PIN, 9'h050);
        settle(2);
        `CHK(out_en_out, 4'ha)
        left = 1;
        wait_level(1'b1);
        settle(2);
        `CHK({detect_level_out, out_en_out}, 5'h15)
        rd_chk(ADDR_PIN_STATUS, 9'h001);
        // tick off: level must freeze against a new raw value
        wr(ADDR_SLOW_CLOCK, 9'h000);
        left = 0;
        normal_en_in = 4'h3;
        settle(40);
        `CHK({detect_level_out, out_en_out}, 5'h11)
        wr(ADDR_SLOW_CLOCK, 9'h001);
        wr(ADDR_DETECT_PIN, 9'h060);
        right = 0;
        wait_level(1'b0);
        settle(2);
        `CHK(out_en_out, 4'h2)
        // shared pin as source: sampled only while its code is input or reserved
        wr(ADDR_DETECT_PIN, 9'h040);
        jack = 1;
        wait_level(1'b1);
        settle(2);
        `CHK(out_en_out, 4'h1)
        wr(ADDR_PIN_FUNC, 9'h006);
        settle(40);
        `CHK({shared_select_pin_oe_out, detect_level_out}, 2'b11)
        wr(ADDR_PIN_FUNC, 9'h000);
        jack = 0;
        wr(ADDR_DETECT_PIN, 9'h020);
        settle(2);
        `CHK(out_en_out, 4'h3)
        wr(ADDR_SOFT_RESET, 9'h1ff);
        rd_chk(ADDR_DETECT_OUTS, RST_DETECT_OUTS);
        rd_chk(ADDR_PIN_FUNC, RST_PIN_FUNC);
    endtask

    initial begin
        repeat (4) @(posedge clock_in);
        @(negedge clock_in);
        rst_in = 0;
        t_defaults();
        t_functions();
        t_three_wire();
        t_cutoff();
        t_detect();
        summarize();
    end
endmodule
`default_nettype wire
